// ### oag_pkg.sv
// package for the operand address mode generator
// assumes a 13-bit word machine with 5-bit bank controls and 17-bit storage addresses
package oag_pkg;
	localparam int WORD_W = 13;
	localparam int ADDR_W = 17;
	localparam int BANK_W = 5;
	localparam int E_W    = 6;
	localparam logic [12:0] SPEC_ADDR_A  = 13'h0fff;
	localparam logic [12:0] SPEC_ADDR_G  = 13'h1fff;
	localparam logic [4:0]  BANK_ZERO    = 5'h00;
	localparam logic [12:0] PC_STEP_ONE  = 13'h0001;
	localparam logic [12:0] PC_STEP_TWO  = 13'h0002;
	localparam logic [12:0] MASK_12      = 13'h0fff;
	localparam logic [12:0] MASK_13      = 13'h1fff;
	typedef enum {
		OAG_IDLE,
		OAG_PTR_WAIT,
		OAG_DONE
	} oag_state_e;
	typedef enum logic [3:0] {
		OAG_MODE_INDEX,
		OAG_MODE_REL_LONG,
		OAG_MODE_PTR_LONG,
		OAG_MODE_CONST,
		OAG_MODE_DIRECT,
		OAG_MODE_INDIRECT,
		OAG_MODE_FORWARD,
		OAG_MODE_BACKWARD,
		OAG_MODE_SPECIFIC,
		OAG_MODE_NOADDR
	} oag_mode_e;
endpackage : oag_pkg

// ### oag_operand_address_mode_generator.sv
// operand effective address and next-pc sequencing for the banked word machine
// assumes a memory port that answers a pointer read with rd_valid one or more clocks later
// assumes every request input comes from decode logic on clk_sys, so none is synchronised
`timescale 1ns/100ps
`default_nettype none
module oag_operand_address_mode_generator (
	// clock and reset
	input  wire logic                        clk_sys,
	input  wire logic                        rst_n,
	// instruction request
	input  wire logic                        start,
	input  wire oag_pkg::oag_mode_e          mode,
	input  wire logic [oag_pkg::E_W-1:0]     e_field,
	input  wire logic [oag_pkg::WORD_W-1:0]  g_word,
	input  wire logic [oag_pkg::WORD_W-1:0]  pc,
	input  wire logic                        wide_mode,
	input  wire logic                        is_store,
	input  wire logic                        take_jump,
	// bank controls
	input  wire logic [oag_pkg::BANK_W-1:0]  bank_direct,
	input  wire logic [oag_pkg::BANK_W-1:0]  bank_indirect,
	input  wire logic [oag_pkg::BANK_W-1:0]  bank_relative,
	// pointer read port
	output logic                             rd_req,
	output logic [oag_pkg::ADDR_W-1:0]       rd_addr,
	input  wire logic                        rd_valid,
	input  wire logic [oag_pkg::WORD_W-1:0]  rd_data,
	// result
	output logic                             done,
	output logic                             busy,
	output logic [oag_pkg::ADDR_W-1:0]       opnd_addr,
	output logic                             opnd_is_imm,
	output logic [oag_pkg::WORD_W-1:0]       opnd_imm,
	output logic                             opnd_write,
	output logic [oag_pkg::WORD_W-1:0]       next_pc
);
	import oag_pkg::*;

	// ********************************************************************
	// helper functions
	// ********************************************************************
	// the shared bit: bank lsb in 12-bit mode, address msb in 13-bit mode
	function automatic logic [ADDR_W-1:0] join_addr(input logic [BANK_W-1:0] bank,
			input logic [WORD_W-1:0] addr, input logic wide);
		logic [ADDR_W-1:0] r;
		if (wide) begin
			r = {bank[BANK_W-1:1], addr};
		end else begin
			r = {bank, addr[WORD_W-2:0]};
		end
		return r;
	endfunction : join_addr

	// wrap at the active width so a relative address never leaves its bank
	function automatic logic [WORD_W-1:0] wrap(input logic [WORD_W-1:0] v, input logic wide);
		logic [WORD_W-1:0] r;
		r = v & (wide ? MASK_13 : MASK_12);
		return r;
	endfunction : wrap

	// ********************************************************************
	// state
	// ********************************************************************
	// sequencing
	oag_state_e              state_q, state_d;
	logic                    busy_q, busy_d;
	logic                    rd_req_q, rd_req_d;
	logic [ADDR_W-1:0]       rd_addr_q, rd_addr_d;
	logic                    done_q, done_d;

	// results, held until the next start; in pointer modes addr_q loads later, with done
	logic [ADDR_W-1:0]       addr_q, addr_d;
	logic                    imm_q, imm_d;
	logic [WORD_W-1:0]       imm_val_q, imm_val_d;
	logic                    wr_q, wr_d;
	logic [WORD_W-1:0]       npc_q, npc_d;

	// taken with start, read when the pointer word returns
	logic [WORD_W-1:0]       add_g_q, add_g_d;
	logic                    wide_q, wide_d;
	logic [BANK_W-1:0]       ibank_q, ibank_d;

	// derived from the request; ptr_sum from the returned pointer word
	logic [WORD_W-1:0]       e_ext;
	logic [WORD_W-1:0]       pc1;
	logic [WORD_W-1:0]       pc2;
	logic [WORD_W-1:0]       rel_long;
	logic [WORD_W-1:0]       rel_fwd;
	logic [WORD_W-1:0]       rel_back;
	logic [ADDR_W-1:0]       spec_addr;
	logic [WORD_W-1:0]       ptr_sum;

	assign e_ext = {{(WORD_W-E_W){1'b0}}, e_field};
	assign pc1   = wrap(pc + PC_STEP_ONE, wide_mode);
	assign pc2   = wrap(pc + PC_STEP_TWO, wide_mode);

	// ********************************************************************
	// relative and fixed addresses
	// ********************************************************************
	// each sum wraps once and feeds both the operand and the jump path;
	// g is added modulo width, so a negative g points backward
	assign rel_long  = wrap(pc + g_word, wide_mode);
	assign rel_fwd   = wrap(pc + e_ext, wide_mode);
	assign rel_back  = wrap(pc - e_ext, wide_mode);
	// bank zero whatever the controls hold
	assign spec_addr = join_addr(BANK_ZERO,
		wide_mode ? SPEC_ADDR_G : SPEC_ADDR_A, wide_mode);
	// stored g is never written back: only the sum is used
	assign ptr_sum   = wrap(rd_data + add_g_q, wide_q);

	// ********************************************************************
	// next state
	// ********************************************************************
	always_comb begin
		state_d   = state_q;
		rd_req_d  = 1'b0;
		rd_addr_d = rd_addr_q;
		done_d    = 1'b0;
		addr_d    = addr_q;
		imm_d     = imm_q;
		imm_val_d = imm_val_q;
		wr_d      = wr_q;
		npc_d     = npc_q;
		add_g_d   = add_g_q;
		wide_d    = wide_q;
		ibank_d   = ibank_q;
		case (state_q)
			OAG_IDLE: begin
				if (start) begin
					wide_d  = wide_mode;
					ibank_d = bank_indirect;
					imm_d   = 1'b0;
					wr_d    = 1'b0;
					add_g_d = '0;
					state_d = OAG_DONE;
					done_d  = 1'b1;
					case (mode)
						OAG_MODE_INDEX: begin
							rd_req_d  = 1'b1;
							rd_addr_d = join_addr(bank_direct, e_ext, wide_mode);
							add_g_d   = g_word;
							npc_d     = pc2;
							state_d   = OAG_PTR_WAIT;
							done_d    = 1'b0;
						end

						OAG_MODE_REL_LONG: begin
							addr_d = join_addr(bank_relative, rel_long, wide_mode);
							npc_d  = take_jump ? rel_long : pc2;
						end

						OAG_MODE_PTR_LONG: begin
							rd_req_d  = 1'b1;
							rd_addr_d = join_addr(bank_direct, g_word, wide_mode);
							npc_d     = pc2;
							state_d   = OAG_PTR_WAIT;
							done_d    = 1'b0;
						end

						OAG_MODE_CONST: begin
							imm_d     = ~is_store;
							imm_val_d = g_word;
							addr_d    = join_addr(bank_relative, pc1, wide_mode);
							wr_d      = is_store;
							npc_d     = pc2;
						end

						OAG_MODE_DIRECT: begin
							addr_d = join_addr(bank_direct, e_ext, wide_mode);
							npc_d  = pc1;
						end

						OAG_MODE_INDIRECT: begin
							rd_req_d  = 1'b1;
							rd_addr_d = join_addr(bank_direct, e_ext, wide_mode);
							npc_d     = pc1;
							state_d   = OAG_PTR_WAIT;
							done_d    = 1'b0;
						end

						OAG_MODE_FORWARD: begin
							addr_d = join_addr(bank_relative, rel_fwd, wide_mode);
							npc_d  = take_jump ? rel_fwd : pc1;
						end

						OAG_MODE_BACKWARD: begin
							addr_d = join_addr(bank_relative, rel_back, wide_mode);
							npc_d  = take_jump ? rel_back : pc1;
						end

						OAG_MODE_SPECIFIC: begin
							addr_d = spec_addr;
							npc_d  = pc1;
						end

						OAG_MODE_NOADDR: begin
							imm_d     = 1'b1;
							imm_val_d = e_ext;
							npc_d     = pc1;
						end

						default: begin
							imm_d     = 1'b1;
							imm_val_d = e_ext;
							npc_d     = pc1;
						end
					endcase
				end
			end

			OAG_PTR_WAIT: begin
				if (rd_valid) begin
					addr_d  = join_addr(ibank_q, ptr_sum, wide_q);
					done_d  = 1'b1;
					state_d = OAG_DONE;
				end
			end

			OAG_DONE: begin
				// a late rd_valid here is ignored
				state_d = OAG_IDLE;
			end

			default: begin
				state_d = OAG_IDLE;
			end
		endcase

		// busy follows the next state so the port comes from a flip-flop
		busy_d = (state_d != OAG_IDLE);
	end

	// ********************************************************************
	// registers
	// ********************************************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q   <= OAG_IDLE;
			busy_q    <= 1'b0;
			rd_req_q  <= 1'b0;
			rd_addr_q <= '0;
			done_q    <= 1'b0;
			addr_q    <= '0;
			imm_q     <= 1'b0;
			imm_val_q <= '0;
			wr_q      <= 1'b0;
			npc_q     <= '0;
			add_g_q   <= '0;
			wide_q    <= 1'b0;
			ibank_q   <= '0;
		end else begin
			state_q   <= state_d;
			busy_q    <= busy_d;
			rd_req_q  <= rd_req_d;
			rd_addr_q <= rd_addr_d;
			done_q    <= done_d;
			addr_q    <= addr_d;
			imm_q     <= imm_d;
			imm_val_q <= imm_val_d;
			wr_q      <= wr_d;
			npc_q     <= npc_d;
			add_g_q   <= add_g_d;
			wide_q    <= wide_d;
			ibank_q   <= ibank_d;
		end
	end

	// ********************************************************************
	// outputs
	// ********************************************************************
	// every port is a register, so no decode glitch reaches the pins
	assign rd_req      = rd_req_q;
	assign rd_addr     = rd_addr_q;
	assign done        = done_q;
	assign busy        = busy_q;
	assign opnd_addr   = addr_q;
	assign opnd_is_imm = imm_q;
	assign opnd_imm    = imm_val_q;
	assign opnd_write  = wr_q;
	assign next_pc     = npc_q;
endmodule : oag_operand_address_mode_generator
`default_nettype wire

// ### oag_checker.sv
// assertions on the operand address generator ports
// assumes it is bound to the generator top module
`timescale 1ns/100ps
`default_nettype none
module oag_checker
	import oag_pkg::*;
(
	// clock, reset, handshake and one-bit request and result flags
	input wire logic clk_sys, rst_n, start, busy, done, rd_req,
	input wire logic rd_valid, wide_mode, is_store, opnd_is_imm,
	// instruction and results
	input wire oag_mode_e mode,
	input wire logic [5:0] e_field,
	input wire logic [12:0] g_word, pc, opnd_imm, next_pc,
	input wire logic [16:0] opnd_addr
);
	// ****************************************
	// address, immediate, next-pc and pointer read handshake checks
	// ****************************************
	logic go;
	assign go = start && !busy;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	noaddr_imm_a: assert property (go && mode == OAG_MODE_NOADDR |=>
		!rd_req && done && opnd_is_imm && opnd_imm == {7'h00, $past(e_field)}) else $error("imm");
	spec_addr_a: assert property (go && mode == OAG_MODE_SPECIFIC |=>
		opnd_addr == ($past(wide_mode) ? 17'h01fff : 17'h00fff)) else $error("specific");
	direct_pc_a: assert property (go && mode == OAG_MODE_DIRECT |=>
		next_pc[11:0] == $past(pc[11:0]) + 12'h001) else $error("direct pc");
	fwd_addr_a: assert property (go && mode == OAG_MODE_FORWARD |=>
		opnd_addr[11:0] == $past(pc[11:0]) + {6'h00, $past(e_field)}) else $error("fwd");
	back_addr_a: assert property (go && mode == OAG_MODE_BACKWARD |=>
		opnd_addr[11:0] == $past(pc[11:0]) - {6'h00, $past(e_field)}) else $error("back");
	const_imm_a: assert property (go && mode == OAG_MODE_CONST && !is_store |=>
		opnd_is_imm && opnd_imm == $past(g_word)) else $error("const");
	ptr_req_a: assert property (go && mode == OAG_MODE_INDIRECT |=> rd_req && !done)
		else $error("no pointer read");
	ptr_done_a: assert property (busy && rd_valid && !rd_req && !done |=> done)
		else $error("no done after read");
	req_pulse_a: assert property (rd_req |=> !rd_req && !done)
		else $error("read pulse");
endmodule : oag_checker
bind oag_operand_address_mode_generator oag_checker u_chk (.clk_sys, .rst_n, .start, .busy,
	.done, .rd_req, .rd_valid, .wide_mode, .is_store, .opnd_is_imm, .mode, .e_field, .g_word,
	.pc, .opnd_imm, .next_pc, .opnd_addr);
`default_nettype wire

// ### oag_operand_address_mode_generator_tb.sv
// self-checking bench for the operand address mode generator
// assumes the package, generator and checker are compiled first
`timescale 1ns/100ps
`default_nettype none
module oag_operand_address_mode_generator_tb;
	import oag_pkg::*;
	// ****************************************
	// stimulus and checking
	// ****************************************
	logic clk_sys, rst_n, start, wide_mode, is_store, take_jump, rd_valid;
	logic rd_req, done, busy, opnd_is_imm, opnd_write;
	oag_mode_e mode;
	logic [5:0] e_field;
	logic [12:0] g_word, pc, rd_data, opnd_imm, next_pc;
	logic [4:0] bank_direct, bank_indirect, bank_relative;
	logic [16:0] rd_addr, opnd_addr;
	int bad_count, n_tests;
	oag_operand_address_mode_generator dut (.clk_sys, .rst_n, .start, .mode, .e_field,
		.g_word, .pc, .wide_mode, .is_store, .take_jump, .bank_direct, .bank_indirect,
		.bank_relative, .rd_req, .rd_addr, .rd_valid, .rd_data, .done, .busy, .opnd_addr,
		.opnd_is_imm, .opnd_imm, .opnd_write, .next_pc);
	function automatic logic [16:0] jn(input logic [4:0] b, input logic [12:0] a, input logic w);
		return w ? {b[4:1], a} : {b, a[11:0]};
	endfunction : jn
	task automatic chk(input logic [16:0] s, x);
		n_tests++;
		if (s !== x) begin
			bad_count++;
			$display("mismatch at %0t seen %h expected %h", $time, s, x);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	// one instruction; a pointer read is answered one clock late
	task automatic op(input oag_mode_e m, input logic [5:0] e, input logic [12:0] g, p,
		input logic w, st, jp, input logic [12:0] d, input logic [16:0] ra);
		int n;
		@(posedge clk_sys);
		mode <= m;
		e_field <= e;
		g_word <= g;
		pc <= p;
		wide_mode <= w;
		is_store <= st;
		take_jump <= jp;
		start <= 1'b1;
		@(posedge clk_sys);
		start <= 1'b0;
		n = 0;
		// outputs launched at an edge are looked at 1 ns later, once settled
		#1;
		while (done !== 1'b1 && n < 20) begin
			n++;
			if (rd_req === 1'b1) begin
				chk(rd_addr, ra);
				@(posedge clk_sys);
				rd_valid <= 1'b1;
				rd_data <= d;
			end else begin
				@(posedge clk_sys);
				rd_valid <= 1'b0;
				rd_data <= ~d;
			end
			#1;
		end
		if (n == 20) bad_count++;
	endtask : op
	task automatic t_pointer;
		op(OAG_MODE_INDEX, 6'h05, 13'h1000, 13'h0040, 1, 0, 0, 13'h01e8, 17'h02005);
		chk(opnd_addr, jn(5'h0a, 13'h11e8, 1'b1));
		chk(17'(next_pc), 17'h00042);
		op(OAG_MODE_PTR_LONG, 6'h00, 13'h0076, 13'h0fff, 0, 0, 0, 13'h0e52, 17'h03076);
		chk(opnd_addr, jn(5'h0a, 13'h0e52, 1'b0));
		chk(17'(next_pc), 17'h00001);
		op(OAG_MODE_INDIRECT, 6'h25, 13'h0000, 13'h0851, 1, 0, 0, 13'h06f5, 17'h02025);
		chk(opnd_addr, jn(5'h0a, 13'h06f5, 1'b1));
		chk(17'(next_pc), 17'h00852);
		$display("pointer modes done");
	endtask : t_pointer
	task automatic t_two_word;
		op(OAG_MODE_REL_LONG, 6'h01, 13'h1ff0, 13'h0200, 1, 0, 0, 13'h0, 17'h0);
		chk(opnd_addr, jn(5'h15, 13'h01f0, 1'b1));
		chk(17'(next_pc), 17'h00202);
		op(OAG_MODE_REL_LONG, 6'h01, 13'h0150, 13'h0200, 1, 0, 1, 13'h0, 17'h0);
		chk(17'(next_pc), 17'h00350);
		chk(opnd_addr, jn(5'h15, 13'h0350, 1'b1));
		op(OAG_MODE_CONST, 6'h00, 13'h0edf, 13'h0041, 1, 0, 0, 13'h0, 17'h0);
		chk(17'({opnd_is_imm, opnd_imm}), 17'h02edf);
		chk(17'(opnd_write), 17'h0);
		chk(17'(next_pc), 17'h00043);
		op(OAG_MODE_CONST, 6'h00, 13'h04e5, 13'h0043, 1, 1, 0, 13'h0, 17'h0);
		chk(17'(opnd_write), 17'h1);
		chk(opnd_addr, jn(5'h15, 13'h0044, 1'b1));
		$display("two word modes done");
	endtask : t_two_word
	task automatic t_short;
		op(OAG_MODE_DIRECT, 6'h3e, 13'h0000, 13'h023d, 0, 0, 0, 13'h0, 17'h0);
		chk(opnd_addr, jn(5'h03, 13'h003e, 1'b0));
		chk(17'(next_pc), 17'h0023e);
		op(OAG_MODE_FORWARD, 6'h3f, 13'h0000, 13'h0ffe, 0, 0, 0, 13'h0, 17'h0);
		chk(opnd_addr, jn(5'h15, 13'h003d, 1'b0));
		chk(17'(next_pc), 17'h00fff);
		op(OAG_MODE_FORWARD, 6'h3f, 13'h0000, 13'h0ffe, 0, 0, 1, 13'h0, 17'h0);
		chk(17'(next_pc), 17'h0003d);
		op(OAG_MODE_BACKWARD, 6'h3f, 13'h0000, 13'h0010, 1, 0, 0, 13'h0, 17'h0);
		chk(opnd_addr, jn(5'h15, 13'h1fd1, 1'b1));
		$display("short modes done");
	endtask : t_short
	task automatic t_fixed;
		op(OAG_MODE_SPECIFIC, 6'h00, 13'h0000, 13'h0177, 1, 0, 0, 13'h0, 17'h0);
		chk(opnd_addr, 17'h01fff);
		chk(17'(next_pc), 17'h00178);
		op(OAG_MODE_SPECIFIC, 6'h00, 13'h0000, 13'h0177, 0, 0, 0, 13'h0, 17'h0);
		chk(opnd_addr, 17'h00fff);
		op(OAG_MODE_NOADDR, 6'h23, 13'h1fff, 13'h0100, 1, 0, 0, 13'h0, 17'h0);
		chk(17'({opnd_is_imm, opnd_imm}), 17'h02023);
		chk(17'(next_pc), 17'h00101);
		$display("fixed modes done");
	endtask : t_fixed
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// whole run needs under 200 clocks
	initial begin
		repeat (2000) @(posedge clk_sys);
		bad_count++;
		report_and_stop();
	end
	initial begin
		{rst_n, start, wide_mode, is_store, take_jump, rd_valid} = 6'h00;
		mode = OAG_MODE_NOADDR;
		{e_field, g_word, pc, rd_data} = 45'h0;
		{bank_direct, bank_indirect, bank_relative} = 15'h0d55;
		bad_count = 0;
		n_tests = 0;
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_pointer();
		t_two_word();
		t_short();
		t_fixed();
		report_and_stop();
	end
endmodule : oag_operand_address_mode_generator_tb
`default_nettype wire
